// [shared/host_port_pkg.sv]
/*
 host_port_pkg: addresses, fields, reset values and cycle counts of the port.
 Assumes both ends run from one 25 MHz clock.
*/
`default_nettype none
package host_port_pkg;
   // ****************************************
   // port addresses seen on the host pins
   // ****************************************
   localparam logic [2:0] PA_CTRL = 3'h0;
   localparam logic [2:0] PA_VEC = 3'h1;
   localparam logic [2:0] PA_STAT = 3'h2;
   localparam logic [2:0] PA_HIGH = 3'h5;
   localparam logic [2:0] PA_MID = 3'h6;
   localparam logic [2:0] PA_LOW = 3'h7;
   // field positions
   localparam int CTRL_RX_IE = 0;
   localparam int CTRL_TX_IE = 1;
   localparam int CTRL_HFLAG_A = 3;
   localparam int CTRL_HFLAG_B = 4;
   localparam int VEC_HC = 7;
   localparam int ST_RXF = 0;
   localparam int ST_TXE = 1;
   localparam int ST_TRANSFER_READY_FLAG = 2;
   localparam int ST_CFA = 3;
   localparam int ST_CFB = 4;
   localparam int ST_HOST_REQUEST_LINE = 7;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [4:0] VEC_RESET = 5'h00;
   localparam logic [12:0] PIN_SYNC_RESET = 13'h1000;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS = 40;
   localparam int T31A_NS = 86;
   localparam int T32A_NS = 126;
   localparam int ROUND_TRIP_CYC = 7;
   localparam int HOLD_PAD_CYC = 2;
   localparam int STROBE_CYC = (T31A_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYCLE_CYC = (T32A_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] HEN_LOW_CNT = 4'(STROBE_CYC + ROUND_TRIP_CYC - 1);
   localparam logic [3:0] HEN_HIGH_CNT = 4'(CYCLE_CYC + HOLD_PAD_CYC - 1);
   // ****************************************
   // controller registers on apb
   // ****************************************
   localparam logic [7:0] RA_CMD = 8'h00;
   localparam logic [7:0] RA_WDATA = 8'h04;
   localparam logic [7:0] RA_RDATA = 8'h08;
   localparam logic [7:0] RA_STAT = 8'h0C;
   localparam logic [7:0] RA_IRQ_ST = 8'h10;
   localparam logic [7:0] RA_IRQ_MASK = 8'h14;
   localparam int CMD_WRITE = 4;
   localparam int CMD_GUARD = 5;
   localparam int CMD_CONS = 6;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_REQ = 1;
endpackage
`default_nettype wire

// [shared/host_port_if.sv]
/*
 host_port_if: the pins between host controller and device port.
 Assumes the data bus is pulled high when nobody drives it.
*/
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
   logic host_enable_strobe_n;
   logic host_read;
   logic [2:0] host_addr;
   logic [7:0] host_data_out;
   logic host_data_oe;
   logic [7:0] dev_data_out;
   logic dev_data_oe;
   logic [7:0] data_bus;
   logic host_request_line_n;
   // resolved bus level, pull-up when idle
   assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hFF);
   modport device (
      input host_enable_strobe_n, host_read, host_addr, data_bus,
      output dev_data_out, dev_data_oe, host_request_line_n
   );
   modport host (
      output host_enable_strobe_n, host_read, host_addr, host_data_out, host_data_oe,
      input data_bus, host_request_line_n
   );
endinterface
`default_nettype wire

// [logic/host_port_device.sv]
/*
 host_port_device: device end of the host port: byte registers, status,
 command, flags, core word side.
 Assumes async host pins; the core shares clk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_port_device (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   host_port_if.device port,
   output logic [23:0] core_receive_word,
   output logic core_word_full,
   input wire logic core_word_take,
   input wire logic [23:0] core_send_word,
   input wire logic core_send_load,
   output logic rx_full_flag,
   input wire logic core_flag_a,
   input wire logic core_flag_b,
   output logic host_flag_a,
   output logic host_flag_b,
   output logic host_command_request,
   output logic [4:0] host_exception_vector,
   input wire logic core_command_ack
);
   logic [12:0] pin_s1, pin_s2;
   logic hen_d, s_hen_n, s_read, start, finish, acc_read, wr_fin, rd_fin;
   logic [2:0] s_addr, acc_addr;
   logic [7:0] s_data, ctrl, status;
   logic [7:0] tx_byte_high, tx_byte_mid, tx_byte_low;
   logic [7:0] rx_byte_high, rx_byte_mid, rx_byte_low;
   logic tx_empty_flag, move;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // two stages per host pin; logic reads stage two only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= host_port_pkg::PIN_SYNC_RESET;
         pin_s2 <= host_port_pkg::PIN_SYNC_RESET;
         hen_d <= 1'b1;
      end else if (ce) begin
         pin_s1 <= {port.host_enable_strobe_n, port.host_read, port.host_addr,
                    port.data_bus};
         pin_s2 <= pin_s1;
         hen_d <= s_hen_n;
      end
   end
   assign {s_hen_n, s_read, s_addr, s_data} = pin_s2;
   assign start = hen_d & ~s_hen_n;
   assign finish = ~hen_d & s_hen_n;
   assign wr_fin = finish & ~acc_read;
   assign rd_fin = finish & acc_read;

   // access kind is fixed at the strobe's falling edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_read <= 1'b1;
         acc_addr <= 3'h0;
      end else if (ce && start) begin
         acc_read <= s_read;
         acc_addr <= s_addr;
      end
   end

   // ****************************************
   // host written registers
   // ****************************************
   // write data taken at the synced strobe rise, bit by bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= host_port_pkg::CTRL_RESET;
         host_exception_vector <= host_port_pkg::VEC_RESET;
         tx_byte_high <= 8'h00;
         tx_byte_mid <= 8'h00;
         tx_byte_low <= 8'h00;
      end else if (ce && wr_fin) begin
         case (acc_addr)
            host_port_pkg::PA_CTRL: ctrl <= s_data;
            host_port_pkg::PA_VEC: host_exception_vector <= s_data[4:0];
            host_port_pkg::PA_HIGH: tx_byte_high <= s_data;
            host_port_pkg::PA_MID: tx_byte_mid <= s_data;
            host_port_pkg::PA_LOW: tx_byte_low <= s_data;
            default: ;
         endcase
      end
   end
   assign host_flag_a = ctrl[host_port_pkg::CTRL_HFLAG_A];
   assign host_flag_b = ctrl[host_port_pkg::CTRL_HFLAG_B];

   // a host write wins over a same-cycle core ack; the sync delay
   // lets the core serve a request just cancelled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_command_request <= 1'b0;
      end else if (ce) begin
         if (wr_fin && acc_addr == host_port_pkg::PA_VEC) begin
            host_command_request <= s_data[host_port_pkg::VEC_HC];
         end else if (core_command_ack) begin
            host_command_request <= 1'b0;
         end
      end
   end

   // ****************************************
   // transmit bytes to core word
   // ****************************************
   assign move = ~tx_empty_flag & ~core_word_full;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_empty_flag <= 1'b1;
      end else if (ce) begin
         if (wr_fin && acc_addr == host_port_pkg::PA_LOW) begin
            tx_empty_flag <= 1'b0;
         end else if (move) begin
            tx_empty_flag <= 1'b1;
         end
      end
   end
   // the three bytes move as one word, never mixed with a later write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_receive_word <= 24'h000000;
         core_word_full <= 1'b0;
      end else if (ce) begin
         if (move) begin
            core_receive_word <= {tx_byte_high, tx_byte_mid, tx_byte_low};
            core_word_full <= 1'b1;
         end else if (core_word_take) begin
            core_word_full <= 1'b0;
         end
      end
   end

   // ****************************************
   // core word to receive bytes
   // ****************************************
   // a core load wins over the host's final low-byte read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_full_flag <= 1'b0;
         {rx_byte_high, rx_byte_mid, rx_byte_low} <= 24'h000000;
      end else if (ce) begin
         if (core_send_load) begin
            rx_full_flag <= 1'b1;
            {rx_byte_high, rx_byte_mid, rx_byte_low} <= core_send_word;
         end else if (rd_fin && acc_addr == host_port_pkg::PA_LOW) begin
            rx_full_flag <= 1'b0;
         end
      end
   end

   // ****************************************
   // status and read data
   // ****************************************
   // core flags shown live; a read may catch them mid-change
   always_comb begin
      status = 8'h00;
      status[host_port_pkg::ST_RXF] = rx_full_flag;
      status[host_port_pkg::ST_TXE] = tx_empty_flag;
      status[host_port_pkg::ST_TRANSFER_READY_FLAG] = tx_empty_flag & ~core_word_full;
      status[host_port_pkg::ST_CFA] = core_flag_a;
      status[host_port_pkg::ST_CFB] = core_flag_b;
      status[host_port_pkg::ST_HOST_REQUEST_LINE] = ~port.host_request_line_n;
   end
   // read data is snapshot at the synced strobe fall
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port.dev_data_out <= 8'h00;
         port.dev_data_oe <= 1'b0;
      end else if (ce) begin
         if (start && s_read) begin
            port.dev_data_oe <= 1'b1;
            case (s_addr)
               host_port_pkg::PA_CTRL: port.dev_data_out <= ctrl;
               host_port_pkg::PA_VEC: port.dev_data_out <=
                  {host_command_request, 2'b00, host_exception_vector};
               host_port_pkg::PA_STAT: port.dev_data_out <= status;
               host_port_pkg::PA_HIGH: port.dev_data_out <= rx_byte_high;
               host_port_pkg::PA_MID: port.dev_data_out <= rx_byte_mid;
               host_port_pkg::PA_LOW: port.dev_data_out <= rx_byte_low;
               default: port.dev_data_out <= 8'h00;
            endcase
         end else if (finish) begin
            port.dev_data_oe <= 1'b0;
         end
      end
   end
   // request line low while an enabled data flag is set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port.host_request_line_n <= 1'b1;
      end else if (ce) begin
         port.host_request_line_n <=
            ~((ctrl[host_port_pkg::CTRL_RX_IE] & rx_full_flag) |
              (ctrl[host_port_pkg::CTRL_TX_IE] & tx_empty_flag));
      end
   end
endmodule // host_port_device
`default_nettype wire

// [logic/host_port_host.sv]
/*
 host_port_host: APB-run host controller driving the port pins.
 Assumes a device with two-flop synchronisers and a 25 MHz clk.
*/
// The APB interface to the registers and the placing of the registers were decided locally.
// Function
// - read receive bytes only after full flag
// - write transmit bytes only while empty flag
// - device moves transmit bytes intact to core
// - core status readable anytime, may be changing
// - stable status needs long strobe and spacing
// - core flag pair may pass through 01/10
// - encoded pair read twice for agreement
// - rewrite vector only while command bit clear
// - command may be cancelled before recognition
// - device may still serve a cancelled command
// - cancel write keeps vector bits unchanged
// - host written bits synchronised bit by bit
// - host inputs sampled and aligned to clock
`timescale 1ns/1ps
`default_nettype none
module host_port_host (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   host_port_if.host port
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_LOW = 4'b0100,
      ST_HIGH = 4'b1000
   } state_t;
   state_t state;
   logic [8:0] in_s1, in_s2;
   logic [7:0] rd_sync, wdata, rdata, sample, first, drive_data;
   logic req_sync, req_d, start, acc, checking, have_first, chk_ok, is_data;
   logic [2:0] cmd_addr, cur_addr;
   logic cmd_write, cmd_guard, cmd_cons, cur_read, cancel;
   logic [3:0] cnt;
   logic [4:0] vec_shadow;
   logic [1:0] irq_status, irq_mask, irq_set;

   // ****************************************
   // pin synchronisers
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1 <= 9'h1FF;
         in_s2 <= 9'h1FF;
         req_d <= 1'b1;
      end else if (ce) begin
         in_s1 <= {port.host_request_line_n, port.data_bus};
         in_s2 <= in_s1;
         req_d <= req_sync;
      end
   end
   assign {req_sync, rd_sync} = in_s2;

   // ****************************************
   // apb slave
   // ****************************************
   // zero wait states: the access phase completes at its first edge
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign acc = psel & penable;
   assign start = acc & pwrite & (paddr == host_port_pkg::RA_CMD) & (state == ST_IDLE);

   // loaded in setup so it stands at the access edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (ce && psel && !penable) begin
         case (paddr)
            host_port_pkg::RA_CMD: prdata <=
               {25'h0000000, cmd_cons, cmd_guard, cmd_write, 1'b0, cmd_addr};
            host_port_pkg::RA_WDATA: prdata <= {24'h000000, wdata};
            host_port_pkg::RA_RDATA: prdata <= {24'h000000, rdata};
            host_port_pkg::RA_STAT: prdata <= {30'h00000000, ~req_sync, state != ST_IDLE};
            host_port_pkg::RA_IRQ_ST: prdata <= {30'h00000000, irq_status};
            host_port_pkg::RA_IRQ_MASK: prdata <= {30'h00000000, irq_mask};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // a command is ignored while one runs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdata <= 8'h00;
         irq_mask <= 2'h0;
         cmd_addr <= 3'h0;
         cmd_write <= 1'b0;
         cmd_guard <= 1'b0;
         cmd_cons <= 1'b0;
      end else if (ce && acc && pwrite) begin
         if (paddr == host_port_pkg::RA_WDATA) begin
            wdata <= pwdata[7:0];
         end
         if (paddr == host_port_pkg::RA_IRQ_MASK) begin
            irq_mask <= pwdata[1:0];
         end
         if (start) begin
            cmd_addr <= pwdata[2:0];
            cmd_write <= pwdata[host_port_pkg::CMD_WRITE];
            cmd_guard <= pwdata[host_port_pkg::CMD_GUARD];
            cmd_cons <= pwdata[host_port_pkg::CMD_CONS];
         end
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   // set wins over a same-cycle clear
   assign irq_set[host_port_pkg::IRQ_REQ] = req_d & ~req_sync;
   assign irq_set[host_port_pkg::IRQ_DONE] =
      (state == ST_HIGH) & (cnt == 4'h0) & ~checking &
      ~(cmd_cons & cur_read & (~have_first | (sample != first)));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= 2'h0;
      end else if (ce) begin
         if (acc && pwrite && paddr == host_port_pkg::RA_IRQ_ST) begin
            irq_status <= (irq_status & ~pwdata[1:0]) | irq_set;
         end else begin
            irq_status <= irq_status | irq_set;
         end
      end
   end
   assign irq = |(irq_status & irq_mask);

   // ****************************************
   // access sequencer
   // ****************************************
   assign is_data = (cmd_addr == host_port_pkg::PA_HIGH) |
                    (cmd_addr == host_port_pkg::PA_MID) | (cmd_addr == host_port_pkg::PA_LOW);
   assign cancel = (cmd_addr == host_port_pkg::PA_VEC) & cmd_write &
                   ~wdata[host_port_pkg::VEC_HC];
   // a guarded data access, or a vector write raising a command, polls its flag first
   assign cur_addr = ~checking ? cmd_addr :
                     (cmd_addr == host_port_pkg::PA_VEC ? host_port_pkg::PA_VEC :
                      host_port_pkg::PA_STAT);
   assign cur_read = checking | ~cmd_write;
   always_comb begin
      if (cmd_addr == host_port_pkg::PA_VEC) begin
         chk_ok = ~sample[host_port_pkg::VEC_HC];
      end else if (cmd_write) begin
         chk_ok = sample[host_port_pkg::ST_TXE];
      end else begin
         chk_ok = sample[host_port_pkg::ST_RXF];
      end
   end
   // a cancel keeps the last vector; only the command bit changes
   assign drive_data = cancel ? {3'h0, vec_shadow} : wdata;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         checking <= 1'b0;
         have_first <= 1'b0;
         first <= 8'h00;
         sample <= 8'h00;
         rdata <= 8'h00;
      end else if (ce) begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  // cancels are never held back by the guard
                  checking <= pwdata[host_port_pkg::CMD_GUARD] &
                     ((pwdata[2:0] >= host_port_pkg::PA_HIGH) |
                      ((pwdata[2:0] == host_port_pkg::PA_VEC) &
                       pwdata[host_port_pkg::CMD_WRITE] &
                       wdata[host_port_pkg::VEC_HC]));
                  have_first <= 1'b0;
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               cnt <= host_port_pkg::HEN_LOW_CNT;
               state <= ST_LOW;
            end
            ST_LOW: begin
               // strobe held past the stable-status width plus the round trip
               if (cnt == 4'h0) begin
                  sample <= rd_sync;
                  cnt <= host_port_pkg::HEN_HIGH_CNT;
                  state <= ST_HIGH;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            ST_HIGH: begin
               // strobe high long enough to space status reads
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else if (checking) begin
                  checking <= ~chk_ok;
                  state <= ST_SETUP;
               end else if (cmd_cons && cur_read &&
                            (!have_first || sample != first)) begin
                  // read again until two reads in a row agree
                  have_first <= 1'b1;
                  first <= sample;
                  state <= ST_SETUP;
               end else begin
                  if (cur_read) begin
                     rdata <= sample;
                  end
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************
   // address and data settle a cycle before the strobe falls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port.host_enable_strobe_n <= 1'b1;
         port.host_read <= 1'b1;
         port.host_addr <= 3'h0;
         port.host_data_out <= 8'h00;
         port.host_data_oe <= 1'b0;
      end else if (ce) begin
         port.host_enable_strobe_n <= state != ST_LOW;
         if (state == ST_SETUP) begin
            port.host_read <= cur_read;
            port.host_addr <= cur_addr;
            port.host_data_out <= drive_data;
            port.host_data_oe <= ~cur_read;
         end else if (state == ST_IDLE) begin
            port.host_read <= 1'b1;
            port.host_data_oe <= 1'b0;
         end
      end
   end

   // shadow follows vector writes that raise a command
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vec_shadow <= host_port_pkg::VEC_RESET;
      end else if (ce && state == ST_SETUP && !checking &&
                   cmd_addr == host_port_pkg::PA_VEC && cmd_write &&
                   wdata[host_port_pkg::VEC_HC]) begin
         vec_shadow <= wdata[4:0];
      end
   end
endmodule // host_port_host
`default_nettype wire

// [test/host_port_sync_handshake_properties.sv]
/*
 host port pin checker: strobe widths, holds, bus ownership.
 Assumes one clock and async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module host_port_sync_handshake_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_enable_strobe_n,
   input wire logic host_read,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe,
   input wire logic dev_data_oe
);
   // ****************************************
   // pin timing
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // long low keeps status settled
   sequence low_phase;
      !host_enable_strobe_n [*8] ##1 !host_enable_strobe_n ##1 host_enable_strobe_n;
   endsequence
   // two device flops forbid an early answer
   sequence dev_answer;
      !dev_data_oe [*2] ##[1:3] dev_data_oe;
   endsequence
   strobe_low_a: assert property ($fell(host_enable_strobe_n) |-> ##1 low_phase)
      else $error("low width");
   strobe_gap_a: assert property ($rose(host_enable_strobe_n) |-> host_enable_strobe_n [*6])
      else $error("high gap");
   addr_hold_a: assert property (!host_enable_strobe_n && $past(!host_enable_strobe_n)
      |-> $stable(host_addr) && $stable(host_read)) else $error("addr moved");
   wdata_hold_a: assert property (!host_enable_strobe_n && host_data_oe
      && $past(!host_enable_strobe_n) |-> $stable(host_data_out)) else $error("write data moved");
   read_answer_a: assert property ($fell(host_enable_strobe_n) && host_read |-> dev_answer)
      else $error("late answer");
   dev_release_a: assert property ($rose(host_enable_strobe_n) |-> ##[0:4] !dev_data_oe)
      else $error("bus kept");
   no_fight_a: assert property (!(host_data_oe && dev_data_oe))
      else $error("bus fight");
   dev_reads_a: assert property (dev_data_oe |-> host_read)
      else $error("dev drove write");
   host_writes_a: assert property (host_data_oe |-> !host_read)
      else $error("host drove read");
endmodule // host_port_sync_handshake_properties
`default_nettype wire

// [test/host_port_sync_handshake_tb.sv]
/*
 bench: APB host controller and device joined by the port.
 Assumes a single 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module host_port_sync_handshake_tb;
   // ****************************************
   // signals, parts and helpers
   // ****************************************
   logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr, b;
   logic [31:0] pwdata, prdata, r;
   logic [23:0] core_receive_word, core_send_word, w;
   logic core_word_full, core_word_take, core_send_load, rx_full_flag, core_flag_a, core_flag_b;
   logic host_flag_a, host_flag_b, host_command_request, core_command_ack;
   logic [4:0] host_exception_vector;
   logic [1:0] v;
   int errors, cmp_count, seed;
   host_port_if port ();
   host_port_host i_host_port_host (.clk, .rst_n, .ce, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .irq, .port(port));
   host_port_device i_host_port_device (.clk, .rst_n, .ce, .port(port), .core_receive_word,
      .core_word_full, .core_word_take, .core_send_word, .core_send_load, .rx_full_flag,
      .core_flag_a, .core_flag_b, .host_flag_a, .host_flag_b, .host_command_request,
      .host_exception_vector, .core_command_ack);
   host_port_sync_handshake_properties i_props (.clk, .rst_n,
      .host_enable_strobe_n(port.host_enable_strobe_n), .host_read(port.host_read),
      .host_addr(port.host_addr), .host_data_out(port.host_data_out),
      .host_data_oe(port.host_data_oe), .dev_data_oe(port.dev_data_oe));
   // free-running clock, 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task print_verdict;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // one apb transfer; read data lands in r
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // command: [6] consensus [5] guard [4] write [2:0] addr
   function automatic logic [7:0] cmd(logic [2:0] a, logic wr, logic g, logic cs);
      return {1'b0, cs, g, wr, 1'b0, a};
   endfunction
   // one pin access; watchdog bounds the busy poll
   task hp(input logic [7:0] c, input logic [7:0] d);
      apb(1'b1, host_port_pkg::RA_WDATA, {24'h0, d});
      apb(1'b1, host_port_pkg::RA_CMD, {24'h0, c});
      do apb(1'b0, host_port_pkg::RA_STAT, 32'h0); while (r[0] !== 1'b0);
      apb(1'b0, host_port_pkg::RA_RDATA, 32'h0);
      b = r[7:0];
   endtask
   task pulse_in(input int k);
      @(posedge clk);
      if (k == 0) core_word_take <= 1'b1; else if (k == 1) core_send_load <= 1'b1;
      else core_command_ack <= 1'b1;
      @(posedge clk);
      {core_word_take, core_send_load, core_command_ack} <= 3'h0;
   endtask
   // cut hangs well past the run length
   initial begin
      #2000000;
      errors++;
      print_verdict;
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      {ce, psel, penable, pwrite, paddr, pwdata, core_send_word, core_word_take} = '0;
      {core_send_load, core_flag_a, core_flag_b, core_command_ack, rst_n} = '0;
      seed = 32'h0376;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      rst_n <= 1'b1;
      @(negedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      chk("rx_full", 32'h0, {31'h0, rx_full_flag});
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, r);
      // words both ways, all-ones corner first
      for (int i = 0; i < 3; i++) begin
         w = (i == 0) ? 24'hFFFFFF : 24'($random(seed));
         for (int k = 2; k >= 0; k--) hp(cmd(3'(7 - k), 1'b1, 1'b1, 1'b0), w[8*k +: 8]);
         chk("core_word", {8'h0, w}, {8'h0, core_receive_word});
         chk("word_full", 32'h1, {31'h0, core_word_full});
         pulse_in(0);
         core_send_word <= ~w;
         pulse_in(1);
         for (int k = 2; k >= 0; k--) begin
            hp(cmd(3'(7 - k), 1'b0, 1'b1, 1'b0), 8'h00);
            chk("rx_byte", {24'h0, ~w[8*k +: 8]}, {24'h0, b});
         end
         chk("rx_full", 32'h0, {31'h0, rx_full_flag});
      end
      // flag pairs, including the 00 to 11 step
      for (int i = 0; i < 4; i++) begin
         v = 2'(i * 3);
         {core_flag_b, core_flag_a} <= v;
         hp(cmd(host_port_pkg::PA_CTRL, 1'b1, 1'b0, 1'b0), {3'h0, v, 3'h0});
         chk("host_flags", {30'h0, v}, {30'h0, host_flag_b, host_flag_a});
         hp(cmd(host_port_pkg::PA_STAT, 1'b0, 1'b0, 1'b1), 8'h00);
         chk("core_flags", {30'h0, v}, {30'h0, b[4:3]});
      end
      // set, cancel keeping vector, core ack
      w = 24'($random(seed));
      hp(cmd(host_port_pkg::PA_VEC, 1'b1, 1'b1, 1'b0), {3'h4, w[4:0]});
      chk("cmd_req", 32'h1, {31'h0, host_command_request});
      hp(cmd(host_port_pkg::PA_VEC, 1'b1, 1'b0, 1'b0), 8'h00);
      chk("cmd_req", 32'h0, {31'h0, host_command_request});
      chk("vector", {27'h0, w[4:0]}, {27'h0, host_exception_vector});
      hp(cmd(host_port_pkg::PA_VEC, 1'b1, 1'b1, 1'b0), {3'h4, w[4:0]});
      pulse_in(2);
      @(negedge clk);
      chk("cmd_ack", 32'h0, {31'h0, host_command_request});
      // done interrupt: masked, unmasked, cleared
      apb(1'b1, host_port_pkg::RA_IRQ_MASK, 32'h0);
      @(negedge clk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, host_port_pkg::RA_IRQ_MASK, 32'h1);
      @(negedge clk);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b1, host_port_pkg::RA_IRQ_ST, 32'h1);
      @(negedge clk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      print_verdict;
   end
endmodule // host_port_sync_handshake_tb
`default_nettype wire
